// ---- npsc_host.sv ----
`timescale 1ns/1ps

// =====================================================
// host system and its bus power controller
module npsc_host #(
  parameter logic PCI_HOST = 1'b1
) (
  input  wire logic clk,        // bus clock
  input  wire logic power_good, // bus power present
  input  wire logic rst_req,    // warm reset request
  output logic      bus_rst_n,  // bus reset
  output logic      isolate_n,  // power good to device
  output logic      pci_mode_n  // host type strap
);
  initial begin
    bus_rst_n = 1'b0;
    isolate_n = 1'b0;
  end
  assign pci_mode_n = ~PCI_HOST;
  // moves just after rising edges so the device sees a settled level
  always @(posedge clk) begin
    isolate_n <= power_good;
    bus_rst_n <= power_good & ~rst_req;
  end
endmodule : npsc_host

// ---- npsc_pkg.sv ----
package npsc_pkg;
  // =====================================================
  // power states
  typedef enum logic [2:0] {
    NPSC_D0U, NPSC_D0A, NPSC_D1, NPSC_D2, NPSC_D3
  } npsc_state_t;

  // =====================================================
  // configuration map (byte offsets in configuration space)
  localparam logic [7:0]  PMC_OFS        = 8'hde;
  localparam logic [7:0]  PMCSR_OFS      = 8'he0;
  localparam logic [7:0]  PM_DRIVER_REGISTER_OFS       = 8'he4;
  localparam logic [7:0]  BAR_CSR_OFS    = 8'h10;
  localparam logic [7:0]  BAR_IO_OFS     = 8'h14;
  localparam logic [7:0]  BAR_MEM_OFS    = 8'h18;

  // =====================================================
  // field positions
  localparam int          PMCSR_PS_LSB   = 0;
  localparam int          PMCSR_PME_EN   = 8;
  localparam int          PMCSR_PME_STS  = 15;
  localparam int          PM_DRIVER_REGISTER_DEEP_EN   = 0;
  localparam int          PM_DRIVER_REGISTER_LINK_WAKE = 1;
  localparam int          PM_DRIVER_REGISTER_PKT_WAKE  = 2;

  // =====================================================
  // capability values, with and without auxiliary power, and register reset values
  localparam logic [15:0] PMC_NO_AUX     = 16'h0622;
  localparam logic [15:0] PMC_WITH_AUX   = 16'hfe22;
  localparam logic [15:0] PMCSR_RST      = 16'h0000;
  localparam logic [7:0]  PM_DRIVER_REGISTER_RST       = 8'h00;
endpackage : npsc_pkg

// ---- npsc_top.sv ----
`timescale 1ns/1ps

// =====================================================
// power state and reset control
// Notes on behaviour
// - power-on leaves device in uninitialized D0
// - base address write moves to active D0
// - uninit D0 answers target, watches no wake events
// - active D0 full function, link-change wake
// - standby entered and left autonomously in D0a
// - D1: no mastering, no interrupts, config only
// - D1 keeps link alive, watches wake events
// - wake drives pme or cstschg by host type
// - D2 as D1, link-down low-power watch
// - link-down low-power sends no idle pulses
// - driver register bit enables link-down mode
// - D3 as D2; pme disabled means minimal power
// - aux strap sampled during bus reset only; alternate reset clears it
// - aux presence changes capability value
// - low alternate reset is power-on reset
// - isolate low ignores bus reset and config strobes, not bus_idle
// - isolate floats bus outputs except pme and cstschg
// - init on reset level, D3 trail, isolate trail
// - init clears config, keeps pme context
// - wake only when pme enable is set
module npsc_top
  import npsc_pkg::*;
(
  input  wire logic        clk,              // bus clock
  input  wire logic        reset_n,          // alternate power-on reset
  input  wire logic        bus_rst_n,        // bus reset
  input  wire logic        isolate_n,        // bus power good
  input  wire logic        flash_addr_bit1,  // shared aux strap pin
  input  wire logic        pci_mode_n,       // low: pci host
  input  wire logic        cfg_wr,           // config write strobe
  input  wire logic        cfg_rd,           // config read strobe
  input  wire logic [7:0]  cfg_addr,         // config byte offset
  input  wire logic [15:0] cfg_wdata,        // config write data
  output logic      [15:0] cfg_rdata,        // config read data
  input  wire logic        bus_idle,         // no traffic pending
  input  wire logic        link_valid,       // link status
  input  wire logic        wake_packet,      // packet match pulse
  output logic             aux_power_present,// sampled strap
  output logic             target_en,        // may answer target cycles
  output logic             cfg_only,         // config accesses only
  output logic             master_en,        // may master the bus
  output logic             intr_en,          // may raise interrupts
  output logic             standby,          // dynamic standby
  output logic             link_keep,        // keep link integrity
  output logic             link_idle_tx,     // send idle/link pulses
  output logic             init_pulse,       // internal initialization
  output logic             bus_out_oe_n,     // low: bus outputs driven
  output logic             pme_o,            // pme pin output
  output logic             pme_oe_n,         // low: pme driven low
  output logic             cstschg           // card status change
);
  import npsc_pkg::*;

  // =====================================================
  // state record
  typedef struct packed {
    npsc_state_t st;
    logic        aux;
    logic        cardbus;
    logic        pme_en;
    logic        pme_sts;
    logic [7:0]  pm_driver_register;
    logic        rst_q;
    logic        iso_q;
    logic        init;
    logic [15:0] rdata;
  } npsc_reg_t;

  npsc_reg_t   s_r;
  npsc_reg_t   s_nxt;
  logic        in_rst;
  logic        bus_rst_trail;
  logic        iso_trail;
  logic        wake_ev;
  logic        deep_pd;
  logic [1:0]  req_ps;

  // =====================================================
  // combinational next state
  always_comb begin
    s_nxt          = s_r;
    s_nxt.init     = 1'b0;
    s_nxt.rst_q    = bus_rst_n;
    s_nxt.iso_q    = isolate_n;
    req_ps         = cfg_wdata[PMCSR_PS_LSB +: 2];
    in_rst         = !bus_rst_n;
    bus_rst_trail  = bus_rst_n && !s_r.rst_q;
    iso_trail      = isolate_n && !s_r.iso_q;
    // pme enable gates every wake source
    wake_ev        = s_r.pme_en && (
                     (wake_packet && s_r.st != NPSC_D0U &&
                      s_r.st != NPSC_D0A) ||
                     (link_valid != s_r.rdata[0] &&
                      s_r.pm_driver_register[PM_DRIVER_REGISTER_LINK_WAKE] &&
                      s_r.st != NPSC_D0U));
    s_nxt.rdata[0] = s_r.rdata[0];
    if (!isolate_n) begin
      // bus reset and config strobes ignored
    end else if (in_rst) begin
      // strap caught while reset is held
      s_nxt.aux = flash_addr_bit1;
      s_nxt.cardbus = pci_mode_n;
      if (s_r.st != NPSC_D3) begin
        s_nxt.init = 1'b1;
        s_nxt.st   = NPSC_D0U;
      end
    end else begin
      if (bus_rst_trail && s_r.st == NPSC_D3) begin
        s_nxt.init = 1'b1;
        s_nxt.st   = NPSC_D0U;
      end else if (cfg_wr) begin
        unique case (cfg_addr)
          BAR_CSR_OFS, BAR_IO_OFS, BAR_MEM_OFS: begin
            if (s_r.st == NPSC_D0U)
              s_nxt.st = NPSC_D0A;
          end
          PMCSR_OFS: begin
            s_nxt.pme_en = cfg_wdata[PMCSR_PME_EN];
            // state encoding written by host
            unique case (req_ps)
              2'h0: if (s_r.st != NPSC_D0U) s_nxt.st = NPSC_D0A;
              2'h1: s_nxt.st = NPSC_D1;
              2'h2: s_nxt.st = NPSC_D2;
              2'h3: s_nxt.st = NPSC_D3;
            endcase
          end
          PM_DRIVER_REGISTER_OFS: s_nxt.pm_driver_register = cfg_wdata[7:0];
          default: ;
        endcase
      end
    end
    if (iso_trail) begin
      s_nxt.init = 1'b1;
      s_nxt.st   = NPSC_D0U;
    end
    // pme context survives initialization; set wins over clear
    if (isolate_n && cfg_wr && cfg_addr == PMCSR_OFS &&
        cfg_wdata[PMCSR_PME_STS])
      s_nxt.pme_sts = 1'b0;
    if (wake_ev)
      s_nxt.pme_sts = 1'b1;
    s_nxt.rdata[0] = link_valid;
    if (isolate_n && cfg_rd) begin
      unique case (cfg_addr)
        PMC_OFS:   s_nxt.rdata[15:1] = s_r.aux ? PMC_WITH_AUX[15:1] :
                                        PMC_NO_AUX[15:1];
        default:   s_nxt.rdata[15:1] = 15'h0000;
      endcase
    end
  end

  // =====================================================
  // registered state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // alternate reset acts as power-on reset
      s_r         <= '0;
      s_r.st      <= NPSC_D0U;
      s_r.pm_driver_register    <= PM_DRIVER_REGISTER_RST;
      s_r.rst_q   <= 1'b1;
      s_r.iso_q   <= 1'b1;
    end else begin
      s_r         <= s_nxt;
    end
  end

  // =====================================================
  // capability read: all 16 bits from the PMC constant; link history in s_r.rdata[0] is not read out
  always_comb begin
    cfg_rdata = (s_r.aux ? PMC_WITH_AUX : PMC_NO_AUX);
    if (cfg_addr == PMCSR_OFS)
      cfg_rdata = {s_r.pme_sts, 6'h00, s_r.pme_en, 8'h00};
    else if (cfg_addr == PM_DRIVER_REGISTER_OFS)
      cfg_rdata = {8'h00, s_r.pm_driver_register};
    else if (cfg_addr != PMC_OFS)
      cfg_rdata = 16'h0000;
  end

  // =====================================================
  // per-state permissions
  // strap is a level caught during reset; an async flop on it would
  // need a port value at reset, so it is clocked instead
  assign aux_power_present = s_r.aux;
  assign target_en    = isolate_n && (s_r.st == NPSC_D0U ||
                        s_r.st == NPSC_D0A);
  assign cfg_only     = s_r.st != NPSC_D0U && s_r.st != NPSC_D0A;
  assign master_en    = isolate_n && s_r.st == NPSC_D0A;
  assign intr_en      = isolate_n && s_r.st == NPSC_D0A;
  // standby relies on host gating clock in idle time
  assign standby      = s_r.st == NPSC_D0A && bus_idle;
  assign deep_pd      = (s_r.st == NPSC_D2 || s_r.st == NPSC_D3) &&
                        !link_valid && s_r.pm_driver_register[PM_DRIVER_REGISTER_DEEP_EN];
  assign link_keep    = !((s_r.st == NPSC_D3) && !s_r.pme_en) &&
                        !deep_pd;
  assign link_idle_tx = link_keep;
  assign init_pulse   = s_r.init;
  assign bus_out_oe_n = !isolate_n || !bus_rst_n;
  assign pme_o        = 1'b0;
  assign pme_oe_n     = !(s_r.pme_sts && s_r.pme_en &&
                          !s_r.cardbus);
  assign cstschg      = s_r.pme_sts && s_r.pme_en && s_r.cardbus;

  // =====================================================
  // checks
  base_wr_act_a: assert property (@(posedge clk) disable iff (!reset_n)
    (isolate_n && bus_rst_n && s_r.rst_q && cfg_wr &&
     cfg_addr == BAR_IO_OFS && s_r.st == NPSC_D0U) |=>
     s_r.st == NPSC_D0A || s_r.init)
    else $error("base write did not activate");
  d1_no_master_a: assert property (@(posedge clk) disable iff (!reset_n)
    s_r.st == NPSC_D1 |-> !master_en && !intr_en && cfg_only)
    else $error("D1 mastering allowed");
  wake_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(s_r.pme_sts) |-> $past(s_r.pme_en))
    else $error("wake without enable");
  pme_cb_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(cstschg && !pme_oe_n))
    else $error("both wake pins active");
  iso_float_a: assert property (@(posedge clk) disable iff (!reset_n)
    !isolate_n |-> bus_out_oe_n && !target_en)
    else $error("bus driven while isolated");
  iso_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!isolate_n && s_r.iso_q && !$past(iso_trail)) |=> $stable(s_r.st))
    else $error("state moved while isolated");
  iso_init_a: assert property (@(posedge clk) disable iff (!reset_n)
    (isolate_n && !s_r.iso_q) |=> s_r.init && s_r.st == NPSC_D0U)
    else $error("no init on isolate trail");
  deep_link_a: assert property (@(posedge clk) disable iff (!reset_n)
    deep_pd |-> !link_idle_tx)
    else $error("pulses sent in deep mode");
  d3_min_a: assert property (@(posedge clk) disable iff (!reset_n)
    (s_r.st == NPSC_D3 && !s_r.pme_en) |-> !link_keep)
    else $error("link kept in D3 without pme");
  strap_a: assert property (@(posedge clk) disable iff (!reset_n)
    (isolate_n && !bus_rst_n) |=> s_r.aux == $past(flash_addr_bit1))
    else $error("strap not sampled");
endmodule : npsc_top

// ---- testbench.sv ----
`timescale 1ns/1ps

module testbench;
  import npsc_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        power_good = 1'b1;
  logic        rst_req = 1'b0;
  logic        flash_addr_bit1 = 1'b0;
  logic        cfg_wr = 1'b0;
  logic        cfg_rd = 1'b0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [15:0] cfg_wdata = 16'h0000;
  logic        bus_idle = 1'b0;
  logic        link_valid = 1'b1;
  logic        wake_packet = 1'b0;
  wire  [15:0] cfg_rdata;
  wire         bus_rst_n, isolate_n, pci_mode_n, aux_power_present;
  wire         target_en, cfg_only, master_en, intr_en, standby;
  wire         link_keep, link_idle_tx, init_pulse, bus_out_oe_n;
  wire         pme_o, pme_oe_n, cstschg;
  int          err_count = 0;
  int          comparisons = 0;

  always #20 clk = ~clk; // 25 MHz

  npsc_host npsc_host_i (.clk(clk), .power_good(power_good),
    .rst_req(rst_req), .bus_rst_n(bus_rst_n), .isolate_n(isolate_n),
    .pci_mode_n(pci_mode_n));
  npsc_top npsc_top_i (.clk(clk), .reset_n(reset_n),
    .bus_rst_n(bus_rst_n), .isolate_n(isolate_n),
    .flash_addr_bit1(flash_addr_bit1), .pci_mode_n(pci_mode_n),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .bus_idle(bus_idle),
    .link_valid(link_valid), .wake_packet(wake_packet),
    .aux_power_present(aux_power_present), .target_en(target_en),
    .cfg_only(cfg_only), .master_en(master_en), .intr_en(intr_en),
    .standby(standby), .link_keep(link_keep),
    .link_idle_tx(link_idle_tx), .init_pulse(init_pulse),
    .bus_out_oe_n(bus_out_oe_n), .pme_o(pme_o), .pme_oe_n(pme_oe_n),
    .cstschg(cstschg));

  // =====================================================
  // shared helpers
  task automatic wrap_up();
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, exp, input string w);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // strobe lasts one cycle and the state change lands in it; the extra cycle is idle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [15:0] m, e,
                     input string w);
    cfg_addr = a;
    cfg_rd = 1'b1;
    #1;
    chk(cfg_rdata & m, e, w);
    cyc(1);
    cfg_rd = 1'b0;
    // idle cycle so a following read does not re-raise the strobe at once
    cyc(1);
  endtask : rdc

  task automatic wake();
    wake_packet = 1'b1;
    cyc(1);
    wake_packet = 1'b0;
    cyc(1);
  endtask : wake

  // bounded: a missing pulse ends the run at once
  task automatic wait_init(input string w);
    for (int i = 0; i < 4 && init_pulse !== 1'b1; i++)
      cyc(1);
    chk(16'(init_pulse), 16'h0001, w);
    if (init_pulse !== 1'b1)
      wrap_up();
  endtask : wait_init

  // =====================================================
  // scenarios
  task automatic t_d0();
    rdc(PMC_OFS, 16'hffff, PMC_NO_AUX, "pmc");
    rdc(8'h40, 16'hffff, 16'h0000, "unmapped read");
    chk(16'(target_en), 16'h0001, "d0u target");
    chk(16'(master_en), 16'h0000, "d0u master");
    wr(BAR_IO_OFS, 16'h1000);
    chk(16'(master_en), 16'h0001, "d0a master");
    chk(16'(intr_en), 16'h0001, "d0a intr");
    bus_idle = 1'b1;
    cyc(1);
    chk(16'(standby), 16'h0001, "standby in");
    bus_idle = 1'b0;
    cyc(1);
    chk(16'(standby), 16'h0000, "standby out");
  endtask : t_d0

  task automatic t_d1();
    wr(PMCSR_OFS, 16'h0001);
    chk(16'(master_en), 16'h0000, "d1 master");
    chk(16'(intr_en), 16'h0000, "d1 intr");
    chk(16'(cfg_only), 16'h0001, "d1 cfg only");
    chk(16'(link_keep), 16'h0001, "d1 link");
    wake();
    chk(16'(pme_oe_n), 16'h0001, "wake disabled");
    wr(PMCSR_OFS, 16'h0101);
    wake();
    chk(16'(pme_oe_n), 16'h0000, "wake pme");
    chk(16'(cstschg), 16'h0000, "no cstschg on pci");
    chk(16'(pme_o), 16'h0000, "pme pulls low");
    rdc(PMCSR_OFS, 16'h8000, 16'h8000, "pme status");
    wr(PMCSR_OFS, 16'h8101);
    chk(16'(pme_oe_n), 16'h0001, "pme cleared");
  endtask : t_d1

  task automatic t_d2();
    wr(PM_DRIVER_REGISTER_OFS, 16'h0001);
    wr(PMCSR_OFS, 16'h0102);
    link_valid = 1'b0;
    cyc(1);
    chk(16'(link_idle_tx), 16'h0000, "deep idle tx");
    wr(PM_DRIVER_REGISTER_OFS, 16'h0000);
    chk(16'(link_idle_tx), 16'h0001, "deep blocked");
    link_valid = 1'b1;
  endtask : t_d2

  task automatic t_bus_reset();
    flash_addr_bit1 = 1'b1;
    rst_req = 1'b1;
    cyc(2);
    chk(16'(init_pulse), 16'h0001, "reset level init");
    chk(16'(bus_out_oe_n), 16'h0001, "reset float");
    rst_req = 1'b0;
    cyc(2);
    flash_addr_bit1 = 1'b0;
    chk(16'(aux_power_present), 16'h0001, "aux strap");
    rdc(PMC_OFS, 16'hffff, PMC_WITH_AUX, "pmc aux");
    chk(16'(master_en), 16'h0000, "config cleared");
    rdc(PMCSR_OFS, 16'h0100, 16'h0100, "pme kept");
  endtask : t_bus_reset

  task automatic t_isolate();
    power_good = 1'b0;
    cyc(2);
    chk(16'(bus_out_oe_n), 16'h0001, "isolate float");
    wr(BAR_IO_OFS, 16'h1000);
    chk(16'(master_en), 16'h0000, "isolate ignores");
    power_good = 1'b1;
    wait_init("isolate trailing init");
  endtask : t_isolate

  task automatic t_d3();
    wr(BAR_CSR_OFS, 16'h2000);
    wr(PMCSR_OFS, 16'h0003);
    chk(16'(link_keep), 16'h0000, "d3 no pme link");
    rst_req = 1'b1;
    cyc(3);
    chk(16'(init_pulse), 16'h0000, "d3 level no init");
    chk(16'(cfg_only), 16'h0001, "d3 kept");
    rst_req = 1'b0;
    wait_init("d3 trailing init");
  endtask : t_d3

  task automatic t_alt_reset();
    wr(BAR_MEM_OFS, 16'h3000);
    reset_n = 1'b0;
    cyc(2);
    reset_n = 1'b1;
    cyc(1);
    chk(16'(master_en), 16'h0000, "alt reset state");
    rdc(PMCSR_OFS, 16'hffff, PMCSR_RST, "alt reset pmcsr");
    rdc(PMC_OFS, 16'hffff, PMC_NO_AUX, "alt reset pmc");
  endtask : t_alt_reset

  initial begin
    cyc(3);
    reset_n = 1'b1;
    t_d0();
    t_d1();
    t_d2();
    t_bus_reset();
    t_isolate();
    t_d3();
    t_alt_reset();
    wrap_up();
  end
endmodule : testbench
